// ===== verilog/ssp_pkg.sv
// Package: register map, field layout, reset values and carrier types of the serial port
package ssp_pkg;

  // ==========================================================================
  // Register map in processor I/O space
  // ==========================================================================
  localparam logic [15:0] ADDR_DATA_WINDOW = 16'hfff0;
  localparam logic [15:0] ADDR_PORT_CONTROL = 16'hfff1;

  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================================
  // Control register field positions
  // ==========================================================================
  localparam int BIT_FREE_RUN = 15;
  localparam int BIT_SOFT_STOP = 14;
  localparam int BIT_TX_DONE = 13;
  localparam int BIT_RX_NONEMPTY = 12;
  localparam int BIT_RX_OVERRUN = 7;
  localparam int BIT_CLOCK_SAMPLE = 6;
  localparam int BIT_TX_FIFO_RESET_N = 5;
  localparam int BIT_RX_FIFO_RESET_N = 4;
  localparam int BIT_LOOPBACK = 0;

  localparam logic [15:0] CTRL_RESET = 16'h0030;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hcf3f;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic clkx;
    logic fsx;
    logic clkr;
    logic fsr;
    logic dr;
  } ssp_pins_type;

  localparam ssp_pins_type PINS_RESET = 5'h00;

  typedef enum logic [1:0] {
    SHIFT_IDLE = 2'b01,
    SHIFT_BUSY = 2'b10
  } ssp_shift_type;

endpackage

// ===== verilog/ssp_port_ctrl.sv
// Serial port control register, four-level FIFOs, shifters and emulation stop logic
//
// Behaviour
// - A FIFO reset bit written zero holds that FIFO in reset.
// - Writing one to a FIFO reset bit lets that FIFO run again.
// - FIFO reset clears pointers and counts, and the receive one also the overrun flag; mode and configuration bits stay.
// - A FIFO held in reset has zero pointers and reads empty.
// - Control register is sixteen bits at I/O address fff1.
// - Free-run bit set: a breakpoint does not stop clock or shifting.
// - Free-run clear: soft-stop zero stops at once, one after the word.
// - Both emulation bits are zero after reset.
// - Reset value sets only the FIFO reset bits; bits 13,12,7,6 read-only.
// - Transmit-complete reads one once written, zero when transmit FIFO drained.
// - Receive-not-empty reads one while receive FIFO holds data.
// - Both FIFOs are four deep behind one data window; transmit MSB first.
module ssp_port_ctrl #(
  parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr_en,
  input wire logic io_rd_en,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic emu_halt,
  input wire logic clkx_pin,
  input wire logic fsx_pin,
  output logic dx_pin,
  input wire logic clkr_pin,
  input wire logic fsr_pin,
  input wire logic dr_pin
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  ssp_pkg::ssp_pins_type meta_q;
  ssp_pkg::ssp_pins_type sync_q;
  ssp_pkg::ssp_pins_type prev_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= ssp_pkg::PINS_RESET;
      sync_q <= ssp_pkg::PINS_RESET;
      prev_q <= ssp_pkg::PINS_RESET;
    end
    else
    begin
      meta_q <= {clkx_pin, fsx_pin, clkr_pin, fsr_pin, dr_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ==========================================================================
  // Port state
  // ==========================================================================
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] txf_q [DEPTH], txf_d [DEPTH];
  logic [15:0] rxf_q [DEPTH], rxf_d [DEPTH];
  logic [PW-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [PW-1:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [CW-1:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  ssp_pkg::ssp_shift_type tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [15:0] tx_shifter_q, tx_shifter_d;
  logic [15:0] rx_shifter_q, rx_shifter_d;
  logic [3:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic dx_q, dx_d;
  logic overrun_q, overrun_d;

  logic free_run, soft_stop, loopback, tx_run_n, rx_run_n;
  logic tx_en, rx_en, tx_new_ok, rx_new_ok;
  logic rclk_now, rclk_old, rfs_now, rfs_old, rdat;
  logic tx_push, tx_pop, rx_push, rx_pop;

  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    txf_d = txf_q;
    rxf_d = rxf_q;
    tx_wp_d = tx_wp_q;
    tx_rp_d = tx_rp_q;
    rx_wp_d = rx_wp_q;
    rx_rp_d = rx_rp_q;
    tx_cnt_d = tx_cnt_q;
    rx_cnt_d = rx_cnt_q;
    tx_st_d = tx_st_q;
    rx_st_d = rx_st_q;
    tx_shifter_d = tx_shifter_q;
    rx_shifter_d = rx_shifter_q;
    tx_bit_d = tx_bit_q;
    rx_bit_d = rx_bit_q;
    dx_d = dx_q;
    overrun_d = overrun_q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;

    free_run = ctrl_q[ssp_pkg::BIT_FREE_RUN];
    soft_stop = ctrl_q[ssp_pkg::BIT_SOFT_STOP];
    loopback = ctrl_q[ssp_pkg::BIT_LOOPBACK];
    tx_run_n = ctrl_q[ssp_pkg::BIT_TX_FIFO_RESET_N];
    rx_run_n = ctrl_q[ssp_pkg::BIT_RX_FIFO_RESET_N];

    // Soft stop lets the word in flight finish but starts no new one
    tx_new_ok = free_run || !emu_halt;
    rx_new_ok = free_run || !emu_halt;
    tx_en = tx_new_ok || (soft_stop && (tx_st_q == ssp_pkg::SHIFT_BUSY));
    rx_en = rx_new_ok || (soft_stop && (rx_st_q == ssp_pkg::SHIFT_BUSY));

    // Loopback feeds the receiver from the transmit side
    rclk_now = loopback ? sync_q.clkx : sync_q.clkr;
    rclk_old = loopback ? prev_q.clkx : prev_q.clkr;
    rfs_now = loopback ? sync_q.fsx : sync_q.fsr;
    rfs_old = loopback ? prev_q.fsx : prev_q.fsr;
    rdat = loopback ? dx_q : sync_q.dr;

    // ------------------------------------------------------------------------
    // Processor access
    // ------------------------------------------------------------------------
    if (io_wr_en && (io_addr == ssp_pkg::ADDR_PORT_CONTROL))
    begin
      ctrl_d = io_wdata & ssp_pkg::CTRL_WRITE_MASK;
    end
    else if (io_wr_en && (io_addr == ssp_pkg::ADDR_DATA_WINDOW))
    begin
      tx_push = tx_run_n && (tx_cnt_q != FULL_COUNT);
    end

    if (io_rd_en && (io_addr == ssp_pkg::ADDR_PORT_CONTROL))
    begin
      rdata_d = ctrl_q;
      rdata_d[ssp_pkg::BIT_TX_DONE] = (tx_cnt_q != '0);
      rdata_d[ssp_pkg::BIT_RX_NONEMPTY] = (rx_cnt_q != '0);
      rdata_d[ssp_pkg::BIT_RX_OVERRUN] = overrun_q;
      rdata_d[ssp_pkg::BIT_CLOCK_SAMPLE] = sync_q.clkx;
    end
    else if (io_rd_en && (io_addr == ssp_pkg::ADDR_DATA_WINDOW))
    begin
      rdata_d = rxf_q[rx_rp_q];
      rx_pop = rx_run_n && (rx_cnt_q != '0);
    end
    else if (io_rd_en)
    begin
      rdata_d = ssp_pkg::ZERO_WORD;
    end

    // ------------------------------------------------------------------------
    // Transmit shifter, MSB first
    // ------------------------------------------------------------------------
    case (tx_st_q)
      ssp_pkg::SHIFT_IDLE:
      begin
        if (tx_new_ok && sync_q.fsx && !prev_q.fsx && (tx_cnt_q != '0) && tx_run_n)
        begin
          tx_shifter_d = txf_q[tx_rp_q];
          dx_d = txf_q[tx_rp_q][ssp_pkg::WORD_W-1];
          tx_bit_d = ssp_pkg::BIT_ZERO;
          tx_pop = 1'b1;
          tx_st_d = ssp_pkg::SHIFT_BUSY;
        end
      end
      ssp_pkg::SHIFT_BUSY:
      begin
        if (tx_en && !sync_q.clkx && prev_q.clkx)
        begin
          if (tx_bit_q == ssp_pkg::LAST_BIT)
          begin
            tx_st_d = ssp_pkg::SHIFT_IDLE;
          end
          else
          begin
            tx_shifter_d = {tx_shifter_q[ssp_pkg::WORD_W-2:0], 1'b0};
            dx_d = tx_shifter_q[ssp_pkg::WORD_W-2];
            tx_bit_d = tx_bit_q + 1'b1;
          end
        end
      end
      default:
      begin
        tx_st_d = ssp_pkg::SHIFT_IDLE;
      end
    endcase

    // ------------------------------------------------------------------------
    // Receive shifter, sampled on falling receive clock
    // ------------------------------------------------------------------------
    case (rx_st_q)
      ssp_pkg::SHIFT_IDLE:
      begin
        if (rx_new_ok && rfs_now && !rfs_old)
        begin
          rx_bit_d = ssp_pkg::BIT_ZERO;
          rx_st_d = ssp_pkg::SHIFT_BUSY;
        end
      end
      ssp_pkg::SHIFT_BUSY:
      begin
        if (rx_en && !rclk_now && rclk_old)
        begin
          rx_shifter_d = {rx_shifter_q[ssp_pkg::WORD_W-2:0], rdat};
          rx_bit_d = rx_bit_q + 1'b1;
          if (rx_bit_q == ssp_pkg::LAST_BIT)
          begin
            rx_st_d = ssp_pkg::SHIFT_IDLE;
            rx_push = rx_run_n && ((rx_cnt_q != FULL_COUNT) || rx_pop);
            overrun_d = overrun_q || (rx_run_n && !rx_push);
            rxf_d[rx_wp_q] = {rx_shifter_q[ssp_pkg::WORD_W-2:0], rdat};
          end
        end
      end
      default:
      begin
        rx_st_d = ssp_pkg::SHIFT_IDLE;
      end
    endcase

    // ------------------------------------------------------------------------
    // FIFO pointers
    // ------------------------------------------------------------------------
    if (tx_push)
    begin
      txf_d[tx_wp_q] = io_wdata;
      tx_wp_d = ptr_next(tx_wp_q);
    end
    if (tx_pop)
    begin
      tx_rp_d = ptr_next(tx_rp_q);
    end
    tx_cnt_d = tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
    if (rx_push)
    begin
      rx_wp_d = ptr_next(rx_wp_q);
    end
    if (rx_pop)
    begin
      rx_rp_d = ptr_next(rx_rp_q);
    end
    rx_cnt_d = rx_cnt_q + CW'(rx_push) - CW'(rx_pop);

    // Pointers and counts clear here, plus the overrun flag for receive; the control word itself is left alone
    if (!ctrl_d[ssp_pkg::BIT_TX_FIFO_RESET_N])
    begin
      tx_wp_d = '0;
      tx_rp_d = '0;
      tx_cnt_d = '0;
    end
    if (!ctrl_d[ssp_pkg::BIT_RX_FIFO_RESET_N])
    begin
      rx_wp_d = '0;
      rx_rp_d = '0;
      rx_cnt_d = '0;
      overrun_d = 1'b0;
    end
    // Writing ones simply stops forcing the clear above, so the FIFO runs
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= ssp_pkg::CTRL_RESET;
      rdata_q <= ssp_pkg::ZERO_WORD;
      txf_q <= '{default: ssp_pkg::ZERO_WORD};
      rxf_q <= '{default: ssp_pkg::ZERO_WORD};
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
      tx_st_q <= ssp_pkg::SHIFT_IDLE;
      rx_st_q <= ssp_pkg::SHIFT_IDLE;
      tx_shifter_q <= ssp_pkg::ZERO_WORD;
      rx_shifter_q <= ssp_pkg::ZERO_WORD;
      tx_bit_q <= ssp_pkg::BIT_ZERO;
      rx_bit_q <= ssp_pkg::BIT_ZERO;
      dx_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      txf_q <= txf_d;
      rxf_q <= rxf_d;
      tx_wp_q <= tx_wp_d;
      tx_rp_q <= tx_rp_d;
      rx_wp_q <= rx_wp_d;
      rx_rp_q <= rx_rp_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_shifter_q <= tx_shifter_d;
      rx_shifter_q <= rx_shifter_d;
      tx_bit_q <= tx_bit_d;
      rx_bit_q <= rx_bit_d;
      dx_q <= dx_d;
      overrun_q <= overrun_d;
    end
  end

  assign io_rdata = rdata_q;
  assign dx_pin = dx_q;

endmodule

// ===== testbench/ssp_port_ctrl_chk.sv
// Checker for the serial port control block
module ssp_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr_en,
  input wire logic io_rd_en,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic emu_halt,
  input wire logic clkx_pin,
  input wire logic fsx_pin,
  input wire logic dx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] WMASK = ssp_pkg::CTRL_WRITE_MASK;
  logic [15:0] ctrl_q, ctrl_d;
  logic [2:0] quiet_q, quiet_d;
  logic [1:0] pins_q;
  wire logic ctl_sel = io_addr == ssp_pkg::ADDR_PORT_CONTROL;
  wire logic dat_sel = io_addr == ssp_pkg::ADDR_DATA_WINDOW;
  // ==========
  // Shadow of control bits and link quiet time
  always_comb
  begin
    ctrl_d = (io_wr_en && ctl_sel) ? (io_wdata & WMASK) : ctrl_q;
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if ({clkx_pin, fsx_pin} != pins_q)
    begin
      quiet_d = 3'h0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= ssp_pkg::CTRL_RESET;
      quiet_q <= 3'h0;
      pins_q <= 2'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      quiet_q <= quiet_d;
      pins_q <= {clkx_pin, fsx_pin};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_unmapped_read: assert property (io_rd_en && !ctl_sel && !dat_sel |=> io_rdata == 16'h0000)
    else $error("unmapped read nonzero");
  a_rdata_holds: assert property (!io_rd_en |=> $stable(io_rdata))
    else $error("read data moved");
  a_rw_bits_keep: assert property ((io_wr_en && ctl_sel) ##1 (io_rd_en && ctl_sel && !io_wr_en)
    |=> (io_rdata & WMASK) == ($past(io_wdata, 2) & WMASK)) else $error("control bits lost");
  a_tx_rst_empty: assert property (io_rd_en && ctl_sel && !io_wr_en && !ctrl_q[5]
    |=> !io_rdata[13]) else $error("tx fifo not empty in reset");
  a_rx_rst_empty: assert property (io_rd_en && ctl_sel && !io_wr_en && !ctrl_q[4]
    |=> !io_rdata[12] && !io_rdata[7]) else $error("rx fifo not empty in reset");
  a_tx_done_set: assert property ((io_wr_en && dat_sel && ctrl_q[5])
    ##1 (io_rd_en && ctl_sel && !io_wr_en) |=> io_rdata[13]) else $error("tx done not set");
  a_dx_quiet: assert property (quiet_q == 3'h7 |-> $stable(dx_pin))
    else $error("dx moved without clock");
  a_halt_freeze: assert property ((emu_halt && ctrl_q[15:14] == 2'b00)[*3] |-> $stable(dx_pin))
    else $error("dx moved while halted");
  cover property (io_wr_en && dat_sel);
  cover property (emu_halt && ctrl_q[15]);
  cover property (io_rd_en && !ctl_sel && !dat_sel);
endmodule
bind ssp_port_ctrl ssp_chk u_ssp_chk (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
  .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .emu_halt(emu_halt), .clkx_pin(clkx_pin), .fsx_pin(fsx_pin), .dx_pin(dx_pin));

// ===== testbench/ssp_peer.sv
// Model of the external serial peer: shared bit clock, frame sync and data
module ssp_peer (
  output logic clk_pin,
  output logic fs_pin,
  output logic dr_pin,
  input wire logic dx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    clk_pin = 1'b0;
    fs_pin = 1'b0;
    dr_pin = 1'b0;
  end
  // Clock stands low between frames; data moves at rising edge, far from the sampling fall
  task automatic xfer(input logic [15:0] send, output logic [15:0] got);
    fs_pin = 1'b1;
    #200;
    for (int i = 15; i >= 0; i--)
    begin
      dr_pin = send[i];
      clk_pin = 1'b1;
      #50;
      got[i] = dx_pin;
      #50;
      clk_pin = 1'b0;
      fs_pin = 1'b0;
      #100;
    end
    dr_pin = !send[0];
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the serial port control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CTL = ssp_pkg::ADDR_PORT_CONTROL;
  localparam logic [15:0] DAT = ssp_pkg::ADDR_DATA_WINDOW;
  logic sys_clk, rst_n, io_wr_en, io_rd_en, emu_halt, clk_pin, fs_pin, dr_pin, dx_pin;
  logic [15:0] io_addr, io_wdata, io_rdata, got;
  int n_mismatch = 0;
  int cmp_count = 0;
  ssp_port_ctrl u_ssp_port_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .emu_halt(emu_halt), .clkx_pin(clk_pin), .fsx_pin(fs_pin), .dx_pin(dx_pin),
    .clkr_pin(clk_pin), .fsr_pin(fs_pin), .dr_pin(dr_pin));
  ssp_peer u_ssp_peer (.clk_pin(clk_pin), .fs_pin(fs_pin), .dr_pin(dr_pin), .dx_pin(dx_pin));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp, input string name);
    @(negedge sys_clk);
    io_addr = a;
    io_rd_en = 1'b1;
    @(negedge sys_clk);
    io_rd_en = 1'b0;
    @(negedge sys_clk);
    chk(name, exp, io_rdata);
  endtask
  // Write, then read control in the very next cycle
  task automatic wrb(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr_en = 1'b1;
    @(negedge sys_clk);
    io_wr_en = 1'b0;
    io_addr = CTL;
    io_rd_en = 1'b1;
    @(negedge sys_clk);
    io_rd_en = 1'b0;
    @(negedge sys_clk);
    chk("ctrl after write", exp, io_rdata);
  endtask
  // Breakpoint lands mid-word: frame sync plus four bit times is 1000 ns
  task automatic halt_after(input int n);
    repeat (n) @(negedge sys_clk);
    emu_halt = 1'b1;
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    {rst_n, io_wr_en, io_rd_en, emu_halt} = 4'h0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    rchk(CTL, 16'h0030, "ctrl reset");
    wrb(CTL, 16'hffff, 16'hcf3f);
    wrb(CTL, 16'h0000, 16'h0000);
    wrb(CTL, 16'h0030, 16'h0030);
    rchk(16'hfff2, 16'h0000, "unmapped");
    wrb(DAT, 16'ha5c3, 16'h2030);
    wrb(DAT, 16'h5a3c, 16'h2030);
    u_ssp_peer.xfer(16'h1234, got);
    chk("tx word 1", 16'ha5c3, got);
    rchk(CTL, 16'h3030, "both busy");
    u_ssp_peer.xfer(16'hbeef, got);
    chk("tx word 2", 16'h5a3c, got);
    rchk(CTL, 16'h1030, "tx drained");
    rchk(DAT, 16'h1234, "rx word 1");
    rchk(DAT, 16'hbeef, "rx word 2");
    rchk(CTL, 16'h0030, "rx drained");
    wrb(CTL, 16'h0031, 16'h0031);
    wrb(DAT, 16'h3c5a, 16'h2031);
    u_ssp_peer.xfer(16'h0000, got);
    chk("loop tx word", 16'h3c5a, got);
    rchk(DAT, 16'h3c5a, "loop rx word");
    wrb(CTL, 16'h0030, 16'h0030);
    wrb(DAT, 16'h1111, 16'h2030);
    wrb(CTL, 16'h0c00, 16'h0c00);
    wrb(CTL, 16'h0c30, 16'h0c30);
    wrb(CTL, 16'h8030, 16'h8030);
    emu_halt = 1'b1;
    wrb(DAT, 16'hc3a5, 16'ha030);
    u_ssp_peer.xfer(16'h0000, got);
    chk("free run word", 16'hc3a5, got);
    wrb(CTL, 16'h0000, 16'h0000);
    wrb(CTL, 16'h0030, 16'h0030);
    wrb(DAT, 16'h0f0f, 16'h2030);
    u_ssp_peer.xfer(16'hffff, got);
    chk("halt dx held", 16'hffff, got);
    rchk(CTL, 16'h2030, "halt stops");
    emu_halt = 1'b0;
    wrb(CTL, 16'h4030, 16'h6030);
    fork
      u_ssp_peer.xfer(16'h0000, got);
      halt_after(40);
    join
    chk("soft stop word", 16'h0f0f, got);
    rchk(CTL, 16'h5030, "soft stop done");
    emu_halt = 1'b0;
    wrb(CTL, 16'h0000, 16'h0000);
    wrb(CTL, 16'h0030, 16'h0030);
    wrb(DAT, 16'ha5c3, 16'h2030);
    // Immediate stop freezes dx on the bit shown when the halt arrives
    fork
      u_ssp_peer.xfer(16'h0000, got);
      halt_after(40);
    join
    chk("stop mid word", 16'ha000, got);
    print_verdict();
  end
endmodule
